// ==== hw/ref_switch_holdover_ctrl.sv ====
// Purpose: Active reference choice and holdover control for loop one.
// Assumes: Reference and feedback clocks are slow against sys_clk and
//          arrive as pins; the tune comparator says if the loop tuning
//          voltage sits above the tracked DAC level.
// Notes:   Summary of operation
// Summary of operation
// RQ1: Mode 6 picks input only on switch events
// RQ2: Pin zero wins, then pin one, else two
// RQ3: Invert bit flips both selector pins first
// RQ4: Entering mode 6 keeps current input
// RQ5: Host sets manual, waits lock, writes 6
// RQ6: Lock flag fall raises switch event
// RQ7: Tune rail crossing enters holdover
// RQ8: Event with holdover: hold, pick pin input
// RQ9: Lock flag must rise between events
// RQ10: Mode 4 steps to next enabled input
// RQ11: Priority zero, one, two; enabled only
// RQ12: Holdover tristates pump, DAC drives tune
// RQ13: Holdover by mode field or force bit
// RQ14: Fixed or tracked holdover DAC sub-modes
// RQ15: Track updates every divided compare period
// RQ16: Host keeps track updates at 100 kHz max
// RQ17: Enter on force or qualified lock loss
// RQ18: Enter on rail trip when fully enabled
// RQ19: Holdover drops lock one, shows status
// RQ20: Lock detector keeps running in holdover
// RQ21: Holdover DAC: manual or last tracked
// RQ22: Holdover status routable to status pins
// RQ23: Disabling holdover mode exits holdover
// RQ24: Auto exit when window lock qualifies
// RQ25: Count in-window compares, one miss unlocks
// RQ26: R and N dividers take 14-bit values
// RQ27: Selector pins and clocks synchronised first
`timescale 1ns/1ns
`include "refsw_cfg.svh"
module ref_switch_holdover_ctrl
	import refsw_pkg::*;
(
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	// Register port
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	// Asynchronous pins
	input  wire pins_t       pins,
	// Loop one outputs
	output logic      [1:0]  active_input,
	output logic             loop1_pump_hiz,
	output logic      [9:0]  dac_out,
	output logic             loop1_lock_flag,
	// Status pins
	output logic             lock_status_pin,
	output logic             holdover_status_pin
);
	// ----------------------------------------
	// Registers
	// ----------------------------------------
	ctrl_t       ctrl;
	logic [31:0] dac_reg;
	logic [31:0] trip_reg;
	logic [31:0] div_reg;
	logic [31:0] lock_reg;
	hold_state_t state;

	wire [9:0]  dac_manual_value = dac_reg[`DAC_MAN_MSB:0];
	wire [13:0] dac_clk_div      = dac_reg[`DAC_DIV_LSB +: 14];
	wire [5:0]  dac_upper_trip   = trip_reg[5:0];
	wire [5:0]  dac_lower_trip   = trip_reg[`TRIP_LO_LSB +: 6];
	wire [13:0] r_div            = div_reg[13:0];
	wire [13:0] n_div            = div_reg[`DIV_N_LSB +: 14];
	wire [7:0]  lock_window_size = lock_reg[7:0];
	wire [13:0] lock_hold_count  = lock_reg[`LOCK_HOLD_LSB +: 14];

	// ----------------------------------------
	// Pin synchronisation and edges
	// ----------------------------------------
	pins_t pins_s;
	logic  ref_q;
	logic  fb_q;

	sync2 #(.W($bits(pins_t))) u_sync ( // see RQ27
		.sys_clk  (sys_clk),
		.rst_n    (rst_n),
		.async_in (pins),
		.sync_out (pins_s)
	);

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ref_q <= 1'b0;
			fb_q  <= 1'b0;
		end else begin
			ref_q <= pins_s.ref_clk;
			fb_q  <= pins_s.fb_clk;
		end
	end

	wire ref_rise = pins_s.ref_clk && !ref_q;
	wire fb_rise  = pins_s.fb_clk && !fb_q;

	// ----------------------------------------
	// Reference, feedback and DAC clock dividers
	// ----------------------------------------
	logic r_tick;
	logic n_tick;
	logic dac_tick;
	logic switch_event;

	div_counter #(.W(14)) u_rdiv ( // see RQ26
		.sys_clk  (sys_clk),
		.rst_n    (rst_n),
		.restart  (switch_event),
		.pulse_in (ref_rise),
		.divisor  (r_div),
		.tick     (r_tick)
	);

	div_counter #(.W(14)) u_ndiv ( // see RQ26
		.sys_clk  (sys_clk),
		.rst_n    (rst_n),
		.restart  (switch_event),
		.pulse_in (fb_rise),
		.divisor  (n_div),
		.tick     (n_tick)
	);

	div_counter #(.W(14)) u_dacdiv ( // see RQ15
		.sys_clk  (sys_clk),
		.rst_n    (rst_n),
		.restart  (1'b0),
		.pulse_in (r_tick),
		.divisor  (dac_clk_div),
		.tick     (dac_tick)
	);

	// ----------------------------------------
	// Window lock detect
	// ----------------------------------------
	// Phase error is the sys_clk count from R tick to the next N tick;
	// an N tick with no R tick pending counts as outside the window.
	logic [7:0]  phase_cnt;
	logic        r_pending;
	logic [13:0] lock_cnt;
	logic        raw_lock;
	logic        enter_hold;

	wire cmp_valid  = n_tick;
	wire cmp_inside = r_pending && (phase_cnt < lock_window_size);
	wire lock_reach = (lock_cnt + 14'h0001 >= lock_hold_count);

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			phase_cnt <= '0;
			r_pending <= 1'b0;
		end else if (r_tick) begin
			phase_cnt <= '0;
			r_pending <= 1'b1;
		end else if (n_tick) begin
			r_pending <= 1'b0;
		end else if (r_pending && phase_cnt != 8'hFF) begin
			phase_cnt <= phase_cnt + 8'h01;
		end
	end

	// Detector restarts on holdover entry so the exit needs a fresh lock
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			lock_cnt <= '0;
			raw_lock <= 1'b0;
		end else if (enter_hold) begin
			lock_cnt <= '0;
			raw_lock <= 1'b0;
		end else if (cmp_valid && !cmp_inside) begin // see RQ25
			lock_cnt <= '0;
			raw_lock <= 1'b0;
		end else if (cmp_valid && !raw_lock) begin // see RQ20
			lock_cnt <= lock_cnt + 14'h0001;
			raw_lock <= lock_reach;
		end
	end

	// ----------------------------------------
	// Tracked DAC and rail detect
	// ----------------------------------------
	logic [9:0] track_val;

	wire [9:0] upper_lvl = `DAC_MAX - {dac_upper_trip, 4'h0};
	wire [9:0] lower_lvl = {dac_lower_trip, 4'h0};
	wire       rail      = (track_val >= upper_lvl) || // see RQ7
	                       (track_val <= lower_lvl);
	wire       holding   = (state == ST_HOLDOVER);

	// Frozen in holdover: the open loop voltage is no longer valid
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			track_val <= 10'h200;
		else if (ctrl.dac_track && !holding && dac_tick) begin // see RQ15
			if (pins_s.tune_above && track_val != `DAC_MAX)
				track_val <= track_val + 10'h001;
			else if (!pins_s.tune_above && track_val != 10'h000)
				track_val <= track_val - 10'h001;
		end
	end

	// ----------------------------------------
	// Switch events
	// ----------------------------------------
	logic flag_q;
	logic armed;

	wire mode_pin  = (ctrl.ref_select_mode == `MODE_AUTO_PIN);
	wire mode_prio = (ctrl.ref_select_mode == `MODE_AUTO_PRIO);
	wire hold_en   = (ctrl.holdover_mode == `HOLD_ENABLED);
	wire flag_fall = flag_q && !loop1_lock_flag;

	assign switch_event = flag_fall && armed && // see RQ6
	                      (mode_pin ||
	                       (mode_prio && !ctrl.lock_loss_detect_off));

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			flag_q <= 1'b0;
			armed  <= 1'b0;
		end else begin
			flag_q <= loop1_lock_flag;
			if (loop1_lock_flag)
				armed <= 1'b1; // see RQ9
			else if (switch_event)
				armed <= 1'b0;
		end
	end

	// ----------------------------------------
	// Active input choice
	// ----------------------------------------
	wire       sel0    = pins_s.sel_zero ^ ctrl.selector_invert; // see RQ3
	wire       sel1    = pins_s.sel_one ^ ctrl.selector_invert;
	wire [1:0] pin_sel = sel0 ? 2'h0 : (sel1 ? 2'h1 : 2'h2); // see RQ2

	function automatic logic [1:0] next_enabled(input logic [1:0] cur,
	                                            input logic [2:0] en);
		logic [1:0] pick;
		logic [1:0] cand;
		pick = cur;
		for (int i = 2; i >= 1; i--) begin
			cand = 2'((int'(cur) + i) % 3);
			if (en[cand])
				pick = cand;
		end
		return pick;
	endfunction : next_enabled

	wire [1:0] prio_next = next_enabled(active_input, // see RQ11
	                                    ctrl.ref_input_enable);

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			active_input <= 2'h0;
		else if (ctrl.ref_select_mode <= 3'h2)
			active_input <= ctrl.ref_select_mode[1:0];
		else if (switch_event && mode_pin) // see RQ4
			active_input <= pin_sel; // see RQ1 RQ8
		else if (switch_event && mode_prio)
			active_input <= prio_next; // see RQ10
	end

	// ----------------------------------------
	// Holdover state machine
	// ----------------------------------------
	wire rail_trip  = rail && ctrl.tune_rail_detect_on && hold_en &&
	                  ctrl.dac_track && ctrl.dac_manual_on; // see RQ18
	wire lock_lost  = flag_fall && !ctrl.lock_loss_detect_off;
	assign enter_hold = !holding && (ctrl.force_holdover || // see RQ13
	                    (hold_en && (lock_lost || rail_trip))); // see RQ17
	wire leave_hold = holding && !ctrl.force_holdover &&
	                  (!hold_en || raw_lock); // see RQ23 RQ24
	hold_state_t next_state;

	always_comb begin
		next_state = state;
		case (state)
			ST_TRACKING: if (enter_hold) next_state = ST_HOLDOVER;
			ST_HOLDOVER: if (leave_hold) next_state = ST_TRACKING;
			default:     next_state = ST_TRACKING;
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			state <= ST_TRACKING;
		else
			state <= next_state;
	end

	// ----------------------------------------
	// Loop outputs and status pins
	// ----------------------------------------
	wire [9:0] next_dac = (holding && ctrl.dac_manual_on) ? // see RQ21
	                      dac_manual_value : track_val; // see RQ14
	wire       hold_dac = holding || ctrl.dac_manual_on;

	function automatic logic pin_mux(input logic [2:0] sel,
	                                 input logic [5:0] src);
		return (sel <= 3'h5) ? src[sel] : 1'b0;
	endfunction : pin_mux

	// Sources: low, lock one, lock two, both, holdover, rail
	wire [5:0] st_src = {rail, holding,
	                     loop1_lock_flag && pins_s.loop2_lock,
	                     pins_s.loop2_lock, loop1_lock_flag, 1'b0};

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			loop1_pump_hiz      <= 1'b0;
			dac_out             <= 10'h200;
			loop1_lock_flag     <= 1'b0;
			lock_status_pin     <= 1'b0;
			holdover_status_pin <= 1'b0;
		end else begin
			loop1_pump_hiz      <= (next_state == ST_HOLDOVER); // see RQ12
			dac_out             <= hold_dac ? next_dac : track_val;
			loop1_lock_flag     <= raw_lock && (next_state != ST_HOLDOVER); // see RQ19
			lock_status_pin     <= pin_mux(ctrl.lock_pin_sel, st_src); // see RQ22
			holdover_status_pin <= pin_mux(ctrl.hold_pin_sel, st_src);
		end
	end

	// ----------------------------------------
	// Register port
	// ----------------------------------------
	wire sel_ctrl = (reg_addr == `OFF_CTRL);
	wire sel_dac  = (reg_addr == `OFF_DAC);
	wire sel_trip = (reg_addr == `OFF_TRIP);
	wire sel_div  = (reg_addr == `OFF_DIV);
	wire sel_lock = (reg_addr == `OFF_LOCK);
	wire sel_stat = (reg_addr == `OFF_STATUS);

	wire [31:0] status_word = {6'h00, track_val, 11'h000, rail,
	                           loop1_lock_flag, holding, active_input};
	wire [31:0] rd_mux = sel_ctrl ? ctrl :
	                     sel_dac  ? dac_reg :
	                     sel_trip ? trip_reg :
	                     sel_div  ? div_reg :
	                     sel_lock ? lock_reg :
	                     sel_stat ? status_word : 32'h0000_0000;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl      <= `CTRL_RST;
			dac_reg   <= `DAC_RST;
			trip_reg  <= `TRIP_RST;
			div_reg   <= `DIV_RST;
			lock_reg  <= `LOCK_RST;
			reg_rdata <= 32'h0000_0000;
		end else begin
			reg_rdata <= reg_rd ? rd_mux : 32'h0000_0000;
			if (reg_wr && sel_ctrl)
				ctrl <= {12'h000, reg_wdata[19:0]};
			if (reg_wr && sel_dac)
				dac_reg <= reg_wdata & 32'h3FFF_03FF;
			if (reg_wr && sel_trip)
				trip_reg <= reg_wdata & 32'h0000_3F3F;
			if (reg_wr && sel_div)
				div_reg <= reg_wdata & 32'h3FFF_3FFF;
			if (reg_wr && sel_lock)
				lock_reg <= reg_wdata & 32'h003F_FFFF;
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	AST_PUMP_HIZ: assert property ( // see RQ12
		holding |-> loop1_pump_hiz)
		else $error("pump not tristated in holdover");
	AST_FLAG_LOW: assert property ( // see RQ19
		holding |-> !loop1_lock_flag)
		else $error("lock flag high in holdover");
	AST_PIN_PICK: assert property ( // see RQ1
		(switch_event && mode_pin && !ctrl.ref_select_mode[0])
		|=> active_input == $past(pin_sel))
		else $error("mode 6 did not take pin choice");
	AST_PIN_KEEP: assert property ( // see RQ4
		(mode_pin && $past(mode_pin) && !$past(switch_event))
		|-> $stable(active_input))
		else $error("active input moved without event");
	AST_FORCE: assert property ( // see RQ13
		ctrl.force_holdover |=> holding)
		else $error("force did not enter holdover");
	AST_DISABLE: assert property ( // see RQ23
		(holding && ctrl.holdover_mode == 2'h0 && !ctrl.force_holdover)
		|=> !holding)
		else $error("holdover kept after disable");
	AST_REARM: assert property ( // see RQ9
		(!armed && !loop1_lock_flag) |-> !switch_event)
		else $error("event without lock return");
	AST_MISS: assert property ( // see RQ25
		(cmp_valid && !cmp_inside) |=> !raw_lock [*2])
		else $error("lock kept after window miss");
	AST_FIXED: assert property ( // see RQ21
		(holding && ctrl.dac_manual_on && $stable(dac_manual_value))
		|=> dac_out == $past(dac_manual_value))
		else $error("fixed holdover value wrong");
	AST_FROZEN: assert property ( // see RQ14
		(holding && $past(holding)) |-> $stable(track_val))
		else $error("tracked value moved in holdover");
	AST_STEP: assert property ( // see RQ11
		(switch_event && mode_prio && |ctrl.ref_input_enable)
		|=> ctrl.ref_input_enable[active_input])
		else $error("stepped to a disabled input");

	COV_PIN_EVENT: cover property (switch_event && mode_pin);
	COV_RAIL: cover property (rail_trip && enter_hold);
	COV_AUTO_EXIT: cover property (holding && raw_lock ##1 !holding);
endmodule : ref_switch_holdover_ctrl

// ==== hw/refsw_cfg.svh ====
// Purpose: Offsets, field positions, reset values and codes for the
//          reference switch and holdover controller.
// Assumes: 32-bit register words on a plain strobe port.
// Notes:   Definitions only.
`ifndef REFSW_CFG_SVH
`define REFSW_CFG_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OFF_CTRL        8'h00
`define OFF_DAC         8'h04
`define OFF_TRIP        8'h08
`define OFF_DIV         8'h0C
`define OFF_LOCK        8'h10
`define OFF_STATUS      8'h14

// ----------------------------------------
// Reset values
// ----------------------------------------
`define CTRL_RST        32'h0000_3800
`define DAC_RST         32'h0001_0200
`define TRIP_RST        32'h0000_0404
`define DIV_RST         32'h0001_0001
`define LOCK_RST        32'h0000_0804

// ----------------------------------------
// Field positions outside the control word
// ----------------------------------------
`define DAC_MAN_MSB     9
`define DAC_DIV_LSB     16
`define TRIP_LO_LSB     8
`define DIV_N_LSB       16
`define LOCK_HOLD_LSB   8
`define ST_HOLD_BIT     2
`define ST_LOCK1_BIT    3
`define ST_RAIL_BIT     4
`define ST_DAC_LSB      16

// ----------------------------------------
// Mode codes and limits
// ----------------------------------------
`define MODE_AUTO_PRIO  3'h4
`define MODE_AUTO_PIN   3'h6
`define HOLD_ENABLED    2'h2
`define DAC_MAX         10'h3FF
`define DIV_MAX         14'h3FFF

`endif

// ==== hw/refsw_pkg.sv ====
// Purpose: Types shared by the reference switch controller.
// Assumes: Constants come from refsw_cfg.svh.
// Notes:   Control word layout matches the control register bits.
package refsw_pkg;

	// ----------------------------------------
	// Control register layout, bit 0 first from the bottom
	// ----------------------------------------
	typedef struct packed {
		logic [11:0] spare;
		logic [2:0]  hold_pin_sel;
		logic [2:0]  lock_pin_sel;
		logic [2:0]  ref_input_enable;
		logic        dac_manual_on;
		logic        dac_track;
		logic        tune_rail_detect_on;
		logic        lock_loss_detect_off;
		logic        force_holdover;
		logic [1:0]  holdover_mode;
		logic        selector_invert;
		logic [2:0]  ref_select_mode;
	} ctrl_t;

	typedef enum logic [0:0] {
		ST_TRACKING = 1'b0,
		ST_HOLDOVER = 1'b1
	} hold_state_t;

	typedef struct packed {
		logic sel_zero;
		logic sel_one;
		logic ref_clk;
		logic fb_clk;
		logic tune_above;
		logic loop2_lock;
	} pins_t;

endpackage : refsw_pkg

// ==== hw/sync2.sv ====
// Purpose: Two-flop synchroniser for a group of asynchronous levels.
// Assumes: Each bit is an independent level.
// Notes:   Only the second stage leaves this module.
`timescale 1ns/1ns
module sync2 #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         sys_clk,
	input  wire logic         rst_n,
	// Levels
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);
	logic [W-1:0] meta;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			meta     <= '0;
			sync_out <= '0;
		end else begin
			meta     <= async_in;
			sync_out <= meta;
		end
	end
endmodule : sync2

// ==== hw/div_counter.sv ====
// Purpose: Pulse divider: one tick every divisor input pulses.
// Assumes: Divisor of zero behaves as one.
// Notes:   A divisor change takes effect on the next input pulse.
`timescale 1ns/1ns
module div_counter #(
	parameter int W = 14
) (
	// Clock and reset
	input  wire logic         sys_clk,
	input  wire logic         rst_n,
	// Control
	input  wire logic         restart,
	input  wire logic         pulse_in,
	input  wire logic [W-1:0] divisor,
	// Result
	output logic              tick
);
	logic [W-1:0] count;
	logic [W-1:0] next_count;
	wire          wrap = (count + W'(1) >= divisor);

	assign next_count = wrap ? '0 : count + W'(1);

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			count <= '0;
			tick  <= 1'b0;
		end else if (restart) begin
			count <= '0;
			tick  <= 1'b0;
		end else begin
			tick <= pulse_in && wrap;
			if (pulse_in)
				count <= next_count;
		end
	end
endmodule : div_counter

// ==== verification/ref_clk_model.sv ====
// Purpose: Far-side model: reference and feedback clocks for loop one.
// Assumes: Period of 16 sys_clk cycles, 8 high and 8 low.
// Notes:   Feedback trails reference by skew+2 cycles.
`timescale 1ns/1ns
module ref_clk_model (
	// Clock and reset
	input  wire logic       sys_clk,
	input  wire logic       rst_n,
	// Control
	input  wire logic       run,
	input  wire logic [3:0] skew,
	// Clocks
	output logic            ref_clk,
	output logic            fb_clk
);
	logic [3:0]  phase;
	logic [15:0] hist;

	// Clocks stand still low while not running
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			phase   <= 4'h0;
			ref_clk <= 1'b0;
			hist    <= 16'h0000;
			fb_clk  <= 1'b0;
		end else begin
			phase   <= run ? phase + 4'h1 : 4'h0;
			ref_clk <= run & ~phase[3];
			hist    <= {hist[14:0], ref_clk};
			fb_clk  <= hist[skew];
		end
	end
endmodule : ref_clk_model

// ==== verification/tb.sv ====
// Purpose: Self-checking bench for the reference switch controller.
// Assumes: Window 4 cycles and hold count 8 from reset; R = N = 1.
// Notes:   Skew 1 stays in the window, skew 8 falls outside it.
`timescale 1ns/1ns
`include "refsw_cfg.svh"
module tb
	import refsw_pkg::*;
;
	logic        sys_clk;
	logic        rst_n;
	logic [7:0]  reg_addr;
	logic [31:0] reg_wdata;
	logic        reg_wr;
	logic        reg_rd;
	logic [31:0] reg_rdata;
	pins_t       pins;
	logic        sel_zero;
	logic        sel_one;
	logic        run;
	logic [3:0]  skew;
	logic        ref_clk;
	logic        fb_clk;
	logic [1:0]  active_input;
	logic        loop1_pump_hiz;
	logic [9:0]  dac_out;
	logic        loop1_lock_flag;
	logic        lock_status_pin;
	logic        holdover_status_pin;
	int          num_errors;
	int          checks;

	assign pins = {sel_zero, sel_one, ref_clk, fb_clk, 1'b0, 1'b1};

	ref_switch_holdover_ctrl ref_switch_holdover_ctrl_inst (
		.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .pins(pins), .active_input(active_input),
		.loop1_pump_hiz(loop1_pump_hiz), .dac_out(dac_out),
		.loop1_lock_flag(loop1_lock_flag),
		.lock_status_pin(lock_status_pin),
		.holdover_status_pin(holdover_status_pin));

	ref_clk_model ref_clk_model_inst (.sys_clk(sys_clk), .rst_n(rst_n),
		.run(run), .skew(skew), .ref_clk(ref_clk), .fb_clk(fb_clk));

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic check(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		checks++;
		if (g !== e) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask : check

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1;
		check("reg_rdata", e, reg_rdata);
	endtask : rd

	// Control word: lock pin shows loop one lock, hold pin holdover
	function automatic logic [31:0] mk(input logic [2:0] md,
		input logic [1:0] hm, input logic inv, input logic frc,
		input logic [2:0] en, input logic man);
		ctrl_t c;
		c = '0;
		c.ref_select_mode  = md;
		c.holdover_mode    = hm;
		c.selector_invert  = inv;
		c.force_holdover   = frc;
		c.ref_input_enable = en;
		c.dac_manual_on    = man;
		c.lock_pin_sel     = 3'h1;
		c.hold_pin_sel     = 3'h4;
		return c;
	endfunction : mk

	task automatic set_skew(input logic [3:0] v);
		@(posedge sys_clk);
		skew <= v;
	endtask : set_skew

	// Which 0 waits on the lock flag, 1 on the pump tristate
	task automatic wait_out(input int which, input logic v, input int n);
		logic s;
		for (int i = 0; i < n; i++) begin
			@(posedge sys_clk);
			#1;
			s = (which == 0) ? loop1_lock_flag : loop1_pump_hiz;
			if (s === v) return;
		end
		num_errors++;
		$display("[ERR] wait %0d expected %b seen %b", which, v, s);
	endtask : wait_out

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset;
		#1;
		check("active_input", 32'h0, active_input);
		check("dac_out", 32'h200, dac_out);
		check("pump_hiz", 32'h0, loop1_pump_hiz);
		rd(`OFF_CTRL, `CTRL_RST);
		rd(`OFF_DAC, `DAC_RST);
		rd(`OFF_TRIP, `TRIP_RST);
		rd(`OFF_LOCK, `LOCK_RST);
		wr(8'h20, 32'hFFFF_FFFF);
		rd(8'h20, 32'h0000_0000);
		rd(`OFF_CTRL, `CTRL_RST);
		wr(`OFF_DIV, 32'h3FFF_3FFF);
		rd(`OFF_DIV, 32'h3FFF_3FFF);
		wr(`OFF_DIV, `DIV_RST);
		$display("test reset done");
	endtask : t_reset

	task automatic t_lock;
		wr(`OFF_CTRL, mk(3'h0, 2'h0, 1'b0, 1'b0, 3'h7, 1'b0));
		@(posedge sys_clk);
		run <= 1'b1;
		wait_out(0, 1'b1, 600);
		@(posedge sys_clk);
		#1;
		check("lock_status_pin", 32'h1, lock_status_pin);
		set_skew(4'h8);
		wait_out(0, 1'b0, 100);
		set_skew(4'h1);
		wait_out(0, 1'b1, 600);
		$display("test lock done");
	endtask : t_lock

	// Pin modes: zero, one, inverted, invert; expected input
	task automatic t_pin_mode;
		logic [3:0] z;
		logic [3:0] o;
		logic [3:0] inv;
		logic [1:0] ex [4];
		z   = 4'b0100;
		o   = 4'b1010;
		inv = 4'b1000;
		ex  = '{2'h2, 2'h1, 2'h0, 2'h0};
		wr(`OFF_CTRL, mk(3'h0, `HOLD_ENABLED, 1'b0, 1'b0, 3'h7, 1'b0));
		wait_out(0, 1'b1, 600);
		wr(`OFF_CTRL, mk(`MODE_AUTO_PIN, `HOLD_ENABLED, 1'b0, 1'b0,
			3'h7, 1'b0));
		@(posedge sys_clk);
		sel_zero <= 1'b0;
		sel_one  <= 1'b1;
		repeat (10) @(posedge sys_clk);
		#1;
		check("active_input", 32'h0, active_input);
		for (int k = 0; k < 4; k++) begin
			wr(`OFF_CTRL, mk(`MODE_AUTO_PIN, `HOLD_ENABLED, inv[k],
				1'b0, 3'h7, 1'b0));
			@(posedge sys_clk);
			sel_zero <= z[k];
			sel_one  <= o[k];
			wait_out(0, 1'b1, 600);
			set_skew(4'h8);
			wait_out(1, 1'b1, 100);
			@(posedge sys_clk);
			#1;
			check("hold_pin", 32'h1, holdover_status_pin);
			check("lock_flag", 32'h0, loop1_lock_flag);
			check("active_input", ex[k], active_input);
			set_skew(4'h1);
			wait_out(1, 1'b0, 800);
			check("active_input", ex[k], active_input);
		end
		$display("test pin mode done");
	endtask : t_pin_mode

	task automatic t_force;
		wr(`OFF_DAC, 32'h0001_0155);
		wr(`OFF_CTRL, mk(3'h0, `HOLD_ENABLED, 1'b0, 1'b1, 3'h7, 1'b1));
		repeat (4) @(posedge sys_clk);
		#1;
		check("pump_hiz", 32'h1, loop1_pump_hiz);
		check("dac_out", 32'h155, dac_out);
		check("lock_flag", 32'h0, loop1_lock_flag);
		wr(`OFF_CTRL, mk(3'h0, 2'h0, 1'b0, 1'b0, 3'h7, 1'b1));
		repeat (4) @(posedge sys_clk);
		#1;
		check("pump_hiz", 32'h0, loop1_pump_hiz);
		$display("test force done");
	endtask : t_force

	task automatic t_prio;
		wr(`OFF_CTRL, mk(3'h0, 2'h0, 1'b0, 1'b0, 3'b101, 1'b0));
		wait_out(0, 1'b1, 600);
		wr(`OFF_CTRL, mk(`MODE_AUTO_PRIO, 2'h0, 1'b0, 1'b0, 3'b101, 1'b0));
		set_skew(4'h8);
		wait_out(0, 1'b0, 100);
		repeat (5) @(posedge sys_clk);
		#1;
		check("active_input", 32'h2, active_input);
		check("pump_hiz", 32'h0, loop1_pump_hiz);
		repeat (60) @(posedge sys_clk);
		#1;
		check("active_input", 32'h2, active_input);
		set_skew(4'h1);
		$display("test priority done");
	endtask : t_prio

	// Tracking walks down from mid scale to the lower level 0x1F0;
	// DAC divider 64 keeps updates near 100 kHz with a 160 ns compare
	task automatic t_track;
		wr(`OFF_DAC, 32'h0040_0155);
		wr(`OFF_TRIP, 32'h0000_1F04);
		wr(`OFF_CTRL, mk(3'h0, `HOLD_ENABLED, 1'b0, 1'b0, 3'h7, 1'b1) |
			32'h0000_0300);
		wait_out(1, 1'b1, 17500);
		@(posedge sys_clk);
		#1;
		check("dac_out", 32'h155, dac_out);
		check("hold_pin", 32'h1, holdover_status_pin);
		rd(`OFF_STATUS, 32'h01F0_0014);
		wr(`OFF_CTRL, mk(3'h0, 2'h0, 1'b0, 1'b0, 3'h7, 1'b0));
		$display("test track done");
	endtask : t_track

	// ----------------------------------------
	// Run control
	// ----------------------------------------
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : report_and_stop

	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	// Tests need roughly 18000 cycles; allow over twice that
	initial begin
		#400000;
		num_errors++;
		report_and_stop();
	end

	initial begin
		num_errors = 0;
		checks     = 0;
		rst_n      = 1'b0;
		reg_addr   = 8'h00;
		reg_wdata  = 32'h0000_0000;
		reg_wr     = 1'b0;
		reg_rd     = 1'b0;
		sel_zero   = 1'b0;
		sel_one    = 1'b0;
		run        = 1'b0;
		skew       = 4'h1;
		repeat (3) @(posedge sys_clk);
		rst_n <= 1'b1;
		t_reset();
		t_lock();
		t_pin_mode();
		t_force();
		t_prio();
		t_track();
		report_and_stop();
	end
endmodule : tb
